//--- logic/ops_sync_ctrl.sv
/*
 * Output prescaler and distribution sync control, top level.
 * Holds the sync sequencer, the pin synchronisers and the channel
 * dividers fed by the prescaler. Assumes status pins from the analog
 * loop, the digital loop and the active reference are asynchronous,
 * and that the oscillator rate is modelled by the system clock.
 */
// The Wishbone slave port is this design's own decision.
// Overview of operation
// - Ratio code sets prescaler divide value
// - Reset bit holds prescaler, zero divides
// - Direct source: sync gated only by loop
// - Reference source: sync waits reference edge
// - Auto sync on frequency or phase lock
// - Unmasked: sync waits calibration and lock
// - Masked: sync ignores analog loop lock
// - Channel B mask frees divider at once
// - Masked channel B ignores all sync
// - Channel B mask leaves drivers untouched

`timescale 1ns/10ps
module ops_sync_ctrl
    import ops_pkg::*;
(
    input  wire logic        clk_sys_i,       // System clock, 50 MHz
    input  wire logic        srst_i,          // Synchronous reset
    input  wire logic        wb_cyc_i,        // Bus cycle
    input  wire logic        wb_stb_i,        // Strobe
    input  wire logic        wb_we_i,         // Write enable
    input  wire logic [15:0] wb_adr_i,        // Byte address
    input  wire logic [3:0]  wb_sel_i,        // Byte enables
    input  wire logic [31:0] wb_dat_i,        // Write data
    output logic [31:0]      wb_dat_o,        // Read data
    output logic             wb_ack_o,        // Acknowledge
    input  wire logic        ref_active_i,    // Active input reference
    input  wire logic        aloop_cal_done_i, // Analog loop calibrated
    input  wire logic        aloop_lock_i,     // Analog loop locked
    input  wire logic        dloop_frq_lock_i, // Digital loop freq lock
    input  wire logic        dloop_phs_lock_i, // Digital loop phase lock
    input  wire logic        chan_b_drv_en_i, // Channel B driver enable
    output logic             chan_b_drv_en_o, // Passed to the drivers
    output logic             presc_tick_o,    // Prescaler output pulse
    output logic             sync_pulse_o,    // Accepted sync event
    output logic [1:0]       chan_clk_o       // Channel divider outputs
);

    // ==================================================================
    // Register slave
    // ==================================================================
    logic [7:0] rst_reg;   // Prescaler reset register
    logic [7:0] ratio_reg; // Prescaler ratio register
    logic [7:0] src_reg;   // Sync source and auto mode
    logic [7:0] mask_reg;  // Sync masks
    logic [7:0] status;    // Live status byte
    logic       soft_sync; // Software sync request

    ops_wb_regs u_regs (
        .clk_sys_i   (clk_sys_i),
        .srst_i      (srst_i),
        .wb_cyc_i    (wb_cyc_i),
        .wb_stb_i    (wb_stb_i),
        .wb_we_i     (wb_we_i),
        .wb_adr_i    (wb_adr_i),
        .wb_sel_i    (wb_sel_i),
        .wb_dat_i    (wb_dat_i),
        .wb_dat_o    (wb_dat_o),
        .wb_ack_o    (wb_ack_o),
        .status_i    (status),
        .rst_reg_o   (rst_reg),
        .ratio_reg_o (ratio_reg),
        .src_reg_o   (src_reg),
        .mask_reg_o  (mask_reg),
        .soft_sync_o (soft_sync)
    );

    // Field decode
    wire [3:0] presc_ratio = ratio_reg[3:0];
    wire       presc_hold  = rst_reg[OPS_BIT_PRESC_RST];
    wire       src_ref     = src_reg[OPS_BIT_SRC_REF];
    wire [1:0] auto_mode   = src_reg[1:0];
    wire       mask_aloop  = mask_reg[OPS_BIT_MASK_ALOOP];
    wire       mask_b      = mask_reg[OPS_BIT_MASK_B];

    // ==================================================================
    // Prescaler
    // ==================================================================
    logic presc_tick; // One pulse per prescaler period

    // Software must reset or recalibrate after a ratio change
    ops_prescaler u_presc (
        .clk_sys_i (clk_sys_i),
        .srst_i    (srst_i),
        .ratio_i   (presc_ratio),
        .hold_i    (presc_hold),
        .tick_o    (presc_tick)
    );

    // ==================================================================
    // Pin synchronisers
    // ==================================================================
    wire  [OPS_NPIN-1:0] pin_raw = {dloop_phs_lock_i, dloop_frq_lock_i,
                                    aloop_lock_i, aloop_cal_done_i,
                                    ref_active_i};
    logic [OPS_NPIN-1:0] pin_s1_r;   // First stage, read by s2 only
    logic [OPS_NPIN-1:0] pin_s2_r;   // Second stage
    logic [OPS_NPIN-1:0] pin_s3_r;   // Third stage
    logic [OPS_NPIN-1:0] pin_q_r;    // Accepted level
    logic [OPS_NPIN-1:0] pin_d_r;    // Accepted level, one cycle late

    genvar gp;
    generate
        for (gp = 0; gp < OPS_NPIN; gp++) begin : g_pin
            // A change counts once stages two and three agree
            always_ff @(posedge clk_sys_i) begin
                if (srst_i) begin
                    pin_s1_r[gp] <= 1'b0;
                    pin_s2_r[gp] <= 1'b0;
                    pin_s3_r[gp] <= 1'b0;
                    pin_q_r[gp]  <= 1'b0;
                    pin_d_r[gp]  <= 1'b0;
                end else begin
                    pin_s1_r[gp] <= pin_raw[gp];
                    pin_s2_r[gp] <= pin_s1_r[gp];
                    pin_s3_r[gp] <= pin_s2_r[gp];
                    if (pin_s2_r[gp] == pin_s3_r[gp]) begin
                        pin_q_r[gp] <= pin_s3_r[gp];
                    end
                    pin_d_r[gp] <= pin_q_r[gp];
                end
            end
        end
    endgenerate

    // Rising edges of the accepted levels
    wire [OPS_NPIN-1:0] pin_rise = pin_q_r & ~pin_d_r;
    wire ref_rise  = pin_rise[OPS_PIN_REF];
    wire aloop_ok  = pin_q_r[OPS_PIN_CAL] && pin_q_r[OPS_PIN_LCK];

    // ==================================================================
    // Sync request and gating
    // ==================================================================
    // Lock mask overrides the analog loop detector
    wire armed     = mask_aloop || aloop_ok;
    // Reserved auto code 11 triggers nothing
    wire auto_req  = ((auto_mode == OPS_AUTO_FREQ) &&
                      pin_rise[OPS_PIN_FRQ]) ||
                     ((auto_mode == OPS_AUTO_PHASE) &&
                      pin_rise[OPS_PIN_PHS]);
    wire sync_req  = soft_sync || auto_req;

    ops_sync_st_t st_r;   // Sequencer state
    ops_sync_st_t st_nxt; // Next state
    logic         sync_fire;

    // Fire when armed, at once or on the next reference edge
    assign sync_fire =
        ((st_r == OPS_ST_PEND) && armed && !src_ref) ||
        ((st_r == OPS_ST_WAIT_REF) && armed && ref_rise);

    // Next state; requests while pending merge into one event
    always_comb begin
        st_nxt = st_r;
        unique case (st_r)
            OPS_ST_IDLE: begin
                if (sync_req) begin
                    st_nxt = OPS_ST_PEND;
                end
            end
            OPS_ST_PEND: begin
                // Held off here until armed: analog loop ready or lock mask set
                if (armed && src_ref) begin
                    st_nxt = OPS_ST_WAIT_REF;
                end else if (armed) begin
                    st_nxt = OPS_ST_IDLE;
                end
            end
            OPS_ST_WAIT_REF: begin
                // Losing lock sends the request back to wait
                if (!armed) begin
                    st_nxt = OPS_ST_PEND;
                end else if (ref_rise) begin
                    st_nxt = OPS_ST_IDLE;
                end
            end
        endcase
        // A new request in the firing cycle is kept, not lost
        if (sync_fire && sync_req) begin
            st_nxt = OPS_ST_PEND;
        end
    end

    // State register
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            st_r <= OPS_ST_IDLE;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ==================================================================
    // Channel dividers
    // ==================================================================
    logic [OPS_NCHAN-1:0] hold_r;   // Static sync state, set at reset
    logic [OPS_NCHAN-1:0] chan_r;   // Divider output level
    logic [OPS_NCHAN-1:0] chan_msk; // Per-channel sync mask
    logic [OPS_NCHAN-1:0] hold_eff; // Hold after masking

    assign chan_msk = {mask_b, 1'b0};
    // Mask frees the divider combinationally, without a clock edge
    assign hold_eff = hold_r & ~chan_msk;

    genvar gc;
    generate
        for (gc = 0; gc < OPS_NCHAN; gc++) begin : g_chan
            // Sync restarts unmasked dividers at phase zero together
            always_ff @(posedge clk_sys_i) begin
                if (srst_i) begin
                    hold_r[gc] <= 1'b1;
                    chan_r[gc] <= 1'b0;
                end else if (sync_fire && !chan_msk[gc]) begin
                    hold_r[gc] <= 1'b0;
                    chan_r[gc] <= 1'b0;
                end else if (presc_tick && !hold_eff[gc]) begin
                    chan_r[gc] <= ~chan_r[gc];
                end
            end
        end
    endgenerate

    // ==================================================================
    // Outputs and status
    // ==================================================================
    // Mask bit never touches the driver enable
    assign chan_b_drv_en_o = chan_b_drv_en_i;
    assign presc_tick_o    = presc_tick;
    assign sync_pulse_o    = sync_fire;
    assign chan_clk_o      = chan_r;
    assign status = {1'b0, hold_eff, (st_r != OPS_ST_IDLE), armed,
                     pin_q_r[OPS_PIN_PHS], pin_q_r[OPS_PIN_FRQ],
                     aloop_ok};

    // ==================================================================
    // Assertions
    // ==================================================================
    AST_PRESC_DIV3: assert property (@(posedge clk_sys_i) disable iff (srst_i)
        (presc_tick && presc_ratio == OPS_RATIO_LOW_MIN && !presc_hold) |->
        ##1 (!presc_tick || presc_hold) [*2]
        ##1 (presc_tick || presc_hold || $changed(presc_ratio)))
        else $error("Prescaler period wrong for ratio three");

    AST_PRESC_HOLD: assert property (@(posedge clk_sys_i) disable iff (srst_i)
        presc_hold |=> !presc_tick)
        else $error("Prescaler ticked while held");

    AST_DIRECT: assert property (@(posedge clk_sys_i) disable iff (srst_i)
        (st_r == OPS_ST_PEND && armed && !src_ref) |->
        sync_pulse_o ##1 (chan_clk_o[0] == 1'b0))
        else $error("Direct sync not issued when armed");

    AST_REF_EDGE: assert property (@(posedge clk_sys_i) disable iff (srst_i)
        (sync_pulse_o && src_ref) |-> (ref_rise && pin_q_r[OPS_PIN_REF]))
        else $error("Reference sync off the reference edge");

    AST_AUTO_RSVD: assert property (@(posedge clk_sys_i) disable iff (srst_i)
        (st_r == OPS_ST_IDLE && auto_mode == OPS_AUTO_RSVD && !soft_sync)
        |=> st_r == OPS_ST_IDLE)
        else $error("Reserved auto mode started a sync");

    AST_AUTO_FREQ: assert property (@(posedge clk_sys_i) disable iff (srst_i)
        (st_r == OPS_ST_IDLE && auto_mode == OPS_AUTO_FREQ &&
         pin_rise[OPS_PIN_FRQ]) |=> st_r == OPS_ST_PEND)
        else $error("Frequency lock did not request sync");

    AST_GATED: assert property (@(posedge clk_sys_i) disable iff (srst_i)
        (sync_pulse_o && !mask_aloop) |->
        (pin_q_r[OPS_PIN_CAL] && pin_q_r[OPS_PIN_LCK]))
        else $error("Sync issued before calibration and lock");

    AST_ALOOP_MASK: assert property (@(posedge clk_sys_i) disable iff (srst_i)
        (mask_aloop && st_r == OPS_ST_PEND && !src_ref) |-> sync_pulse_o)
        else $error("Lock mask did not release sync");

    AST_B_FREE: assert property (@(posedge clk_sys_i) disable iff (srst_i)
        (mask_b && presc_tick) |=> $changed(chan_clk_o[OPS_CHAN_B]))
        else $error("Masked channel B not toggling");

    AST_B_IGNORE: assert property (@(posedge clk_sys_i) disable iff (srst_i)
        (sync_pulse_o && mask_b && !presc_tick) |=>
        $stable(chan_clk_o[OPS_CHAN_B]))
        else $error("Masked channel B took a sync");

    AST_DRV_EN: assert property (@(posedge clk_sys_i) disable iff (srst_i)
        $rose(mask_b) |-> (chan_b_drv_en_o == chan_b_drv_en_i))
        else $error("Channel B mask changed driver enable");

    AST_RESTART: assert property (@(posedge clk_sys_i) disable iff (srst_i)
        (sync_pulse_o && !mask_b) |=>
        (chan_clk_o == 2'b00) && (hold_eff == 2'b00))
        else $error("Sync did not restart dividers together");

endmodule

//--- shared/ops_pkg.sv
/*
 * Shared constants for the output prescaler and distribution sync block:
 * register indices, field positions, reset values and sync state codes.
 * Assumes a 32-bit classic Wishbone register bus with byte addresses.
 */
package ops_pkg;

    // ==================================================================
    // Register indices (byte address is four times the index)
    // ==================================================================
    localparam logic [13:0] OPS_IDX_PRESC_RST  = 14'h0433; // Prescaler reset
    localparam logic [13:0] OPS_IDX_PRESC_RAT  = 14'h0434; // prescaler_ratio
    localparam logic [13:0] OPS_IDX_SYNC_SRC   = 14'h0435; // Source and auto
    localparam logic [13:0] OPS_IDX_SYNC_MASK  = 14'h0436; // sync_mask_control
    localparam logic [13:0] OPS_IDX_SYNC_STAT  = 14'h0437; // Status, soft sync

    // ==================================================================
    // Field positions
    // ==================================================================
    localparam int OPS_BIT_PRESC_RST  = 1;  // Prescaler held in reset
    localparam int OPS_BIT_SRC_REF    = 2;  // Sync on active reference
    localparam int OPS_BIT_MASK_ALOOP = 2;  // Ignore analog loop lock
    localparam int OPS_BIT_MASK_B     = 1;  // Channel B sync mask
    localparam int OPS_BIT_SOFT_SYNC  = 0;  // Write one: request a sync

    // ==================================================================
    // Reset values and codes
    // ==================================================================
    localparam logic [7:0] OPS_RST_REG8      = 8'h00;
    localparam logic [3:0] OPS_RATIO_LOW_MIN = 4'h3;  // Lowest test ratio
    localparam logic [1:0] OPS_AUTO_OFF      = 2'b00;
    localparam logic [1:0] OPS_AUTO_FREQ     = 2'b01;
    localparam logic [1:0] OPS_AUTO_PHASE    = 2'b10;
    localparam logic [1:0] OPS_AUTO_RSVD     = 2'b11;

    // Channel dividers fed by the prescaler
    localparam int OPS_NCHAN   = 2;
    localparam int OPS_CHAN_B  = 1;
    // Pin inputs: reference, cal done, lock, freq lock, phase lock
    localparam int OPS_NPIN    = 5;
    localparam int OPS_PIN_REF = 0;
    localparam int OPS_PIN_CAL = 1;
    localparam int OPS_PIN_LCK = 2;
    localparam int OPS_PIN_FRQ = 3;
    localparam int OPS_PIN_PHS = 4;

    // Sync request sequencer
    typedef enum logic [1:0] {
        OPS_ST_IDLE,
        OPS_ST_PEND,
        OPS_ST_WAIT_REF
    } ops_sync_st_t;

endpackage

//--- logic/ops_prescaler.sv
/*
 * Output prescaler: divides the oscillator rate, modelled as the system
 * clock, by the programmed ratio and emits a one-cycle enable pulse.
 * Assumes ratio and hold come from registers on the same clock.
 */
`timescale 1ns/10ps
module ops_prescaler
    import ops_pkg::*;
(
    input  wire logic       clk_sys_i,   // System clock
    input  wire logic       srst_i,      // Synchronous reset
    input  wire logic [3:0] ratio_i,     // Divide ratio code
    input  wire logic       hold_i,      // Hold in reset
    output logic            tick_o       // One pulse per output period
);

    // ==================================================================
    // Down counter
    // ==================================================================
    logic [3:0] cnt_r;   // Cycles left in this period
    logic [3:0] cnt_nxt; // Next count
    logic       tick_r;  // Registered pulse

    // Reload at zero; codes 0 and 1 are undefined, left as they fall
    assign cnt_nxt = (cnt_r == 4'h0) ? ratio_i - 4'h1 : cnt_r - 4'h1;

    // Counter and pulse; hold keeps the counter parked and silent
    always_ff @(posedge clk_sys_i) begin
        if (srst_i || hold_i) begin
            cnt_r  <= 4'h0;
            tick_r <= 1'b0;
        end else begin
            cnt_r  <= cnt_nxt;
            tick_r <= (cnt_nxt == 4'h0);
        end
    end

    assign tick_o = tick_r;

endmodule

//--- logic/ops_wb_regs.sv
/*
 * Classic Wishbone register slave for the prescaler and sync controls.
 * Assumes a single-cycle master that holds its request until ack.
 */
`timescale 1ns/10ps
module ops_wb_regs
    import ops_pkg::*;
(
    input  wire logic        clk_sys_i,   // System clock
    input  wire logic        srst_i,      // Synchronous reset
    input  wire logic        wb_cyc_i,    // Bus cycle
    input  wire logic        wb_stb_i,    // Strobe
    input  wire logic        wb_we_i,     // Write enable
    input  wire logic [15:0] wb_adr_i,    // Byte address
    input  wire logic [3:0]  wb_sel_i,    // Byte enables
    input  wire logic [31:0] wb_dat_i,    // Write data
    output logic [31:0]      wb_dat_o,    // Read data
    output logic             wb_ack_o,    // Acknowledge
    input  wire logic [7:0]  status_i,    // Live status byte
    output logic [7:0]       rst_reg_o,   // Prescaler reset register
    output logic [7:0]       ratio_reg_o, // Ratio register
    output logic [7:0]       src_reg_o,   // Source and auto register
    output logic [7:0]       mask_reg_o,  // Mask register
    output logic             soft_sync_o  // One-cycle sync request
);

    // ==================================================================
    // Decode
    // ==================================================================
    logic        ack_r;                 // Ack, one cycle per request
    logic [31:0] rdat_r;                // Read data
    logic [7:0]  rst_r, rat_r, src_r, msk_r;
    logic        soft_r;                // Sync request pulse
    wire  [13:0] idx   = wb_adr_i[15:2];
    wire         req   = wb_cyc_i && wb_stb_i && !ack_r;
    wire         wr_b0 = req && wb_we_i && wb_sel_i[0];
    wire  [7:0]  rd_mux =
        (idx == OPS_IDX_PRESC_RST) ? rst_r :
        (idx == OPS_IDX_PRESC_RAT) ? rat_r :
        (idx == OPS_IDX_SYNC_SRC)  ? src_r :
        (idx == OPS_IDX_SYNC_MASK) ? msk_r :
        (idx == OPS_IDX_SYNC_STAT) ? status_i : 8'h00;

    // Handshake; unmapped addresses answer with zero data
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            ack_r  <= 1'b0;
            rdat_r <= 32'h0000_0000;
        end else begin
            ack_r  <= req;
            rdat_r <= {24'h00_0000, rd_mux};
        end
    end

    // Register writes; reserved bits are stored as zero
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            rst_r  <= OPS_RST_REG8;
            rat_r  <= OPS_RST_REG8;
            src_r  <= OPS_RST_REG8;
            msk_r  <= OPS_RST_REG8;
            soft_r <= 1'b0;
        end else begin
            soft_r <= wr_b0 && (idx == OPS_IDX_SYNC_STAT) &&
                      wb_dat_i[OPS_BIT_SOFT_SYNC];
            if (wr_b0 && idx == OPS_IDX_PRESC_RST) begin
                rst_r <= {6'h00, wb_dat_i[1], 1'b0};
            end
            if (wr_b0 && idx == OPS_IDX_PRESC_RAT) begin
                rat_r <= {4'h0, wb_dat_i[3:0]};
            end
            if (wr_b0 && idx == OPS_IDX_SYNC_SRC) begin
                src_r <= {5'h00, wb_dat_i[2:0]};
            end
            if (wr_b0 && idx == OPS_IDX_SYNC_MASK) begin
                msk_r <= {5'h00, wb_dat_i[2:1], 1'b0};
            end
        end
    end

    assign wb_ack_o    = ack_r;
    assign wb_dat_o    = rdat_r;
    assign rst_reg_o   = rst_r;
    assign ratio_reg_o = rat_r;
    assign src_reg_o   = src_r;
    assign mask_reg_o  = msk_r;
    assign soft_sync_o = soft_r;

endmodule

//--- dv/output_prescaler_sync_control_test.sv
/*
 * Self-checking bench for the prescaler and distribution sync block.
 * Assumes the top module ops_sync_ctrl and the ops_pkg constants.
 */
`timescale 1ns/10ps
module output_prescaler_sync_control_test
    import ops_pkg::*;
;
    // ==============================================================
    // Stimulus and observed signals
    // ==============================================================
    logic        clk_sys_i = 1'b0;   // 50 MHz clock
    logic        srst_i    = 1'b1;   // Reset, held at start
    logic        wb_cyc_i  = 1'b0;   // Bus request lines
    logic        wb_stb_i  = 1'b0;
    logic        wb_we_i   = 1'b0;
    logic [15:0] wb_adr_i  = 16'h0000;
    logic [3:0]  wb_sel_i  = 4'h0;
    logic [31:0] wb_dat_i  = 32'h0000_0000;
    logic [31:0] wb_dat_o;
    logic        wb_ack_o;
    logic        ref_i = 1'b0, cal_i = 1'b0, lck_i = 1'b0; // Pins
    logic        frq_i = 1'b0, phs_i = 1'b0, drv_i = 1'b0;
    logic        drv_o, tick_o, sync_o;
    logic [1:0]  chan_o;
    int          err_count = 0, n_tests = 0, cyc = 0, n, k;
    logic [31:0] rd;
    logic        seen;

    always #10 clk_sys_i = ~clk_sys_i;

    ops_sync_ctrl uut (.clk_sys_i(clk_sys_i), .srst_i(srst_i),
        .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
        .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .ref_active_i(ref_i),
        .aloop_cal_done_i(cal_i), .aloop_lock_i(lck_i),
        .dloop_frq_lock_i(frq_i), .dloop_phs_lock_i(phs_i),
        .chan_b_drv_en_i(drv_i), .chan_b_drv_en_o(drv_o),
        .presc_tick_o(tick_o), .sync_pulse_o(sync_o), .chan_clk_o(chan_o));

    // ==============================================================
    // Tasks
    // ==============================================================
    task automatic finish_test();
        $display("errors %0d, checks %0d", err_count, n_tests);
        if (err_count == 0 && n_tests > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_tests++;
        if (g !== e) begin
            err_count++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
        end
    endtask

    // One classic cycle; waits for ack, takes data at that edge
    task automatic wb(input logic we, input logic [13:0] idx,
                      input logic [7:0] d, output logic [31:0] q);
        @(posedge clk_sys_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= {idx, 2'b00};
        wb_sel_i <= 4'hF;
        wb_dat_i <= {24'h00_0000, d};
        do @(posedge clk_sys_i); while (wb_ack_o !== 1'b1);
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i  <= 1'b0;
    endtask

    // Cycles between two settled prescaler ticks
    task automatic gap(output int g);
        g = 0;
        repeat (2) do @(posedge clk_sys_i); while (tick_o !== 1'b1);
        do begin @(posedge clk_sys_i); g++; end while (tick_o !== 1'b1);
    endtask

    // Watch for a sync pulse; channel A must restart right after it
    task automatic wsync(input int w, output logic s);
        logic nxt;
        s = 1'b0;
        nxt = 1'b0;
        repeat (w) begin
            @(posedge clk_sys_i);
            if (nxt) chk({31'h0, chan_o[0]}, 32'h0);
            nxt = (sync_o === 1'b1);
            if (nxt) s = 1'b1;
        end
    endtask

    // Hang guard, far above the expected run length
    always @(posedge clk_sys_i) begin
        cyc++;
        if (cyc == 6000) begin
            err_count++;
            finish_test();
        end
    end

    // ==============================================================
    // Main sequence
    // ==============================================================
    initial begin
        repeat (3) @(posedge clk_sys_i);
        srst_i <= 1'b0;
        wb(0, OPS_IDX_PRESC_RAT, 8'h00, rd); chk(rd, 32'h0);
        wb(0, OPS_IDX_SYNC_SRC, 8'h00, rd);  chk(rd, 32'h0);
        wb(0, OPS_IDX_SYNC_MASK, 8'h00, rd); chk(rd, 32'h0);
        wb(0, OPS_IDX_SYNC_STAT, 8'h00, rd); chk(rd, 32'h60);
        wb(0, 14'h0500, 8'h00, rd);          chk(rd, 32'h0);
        // Ratio codes 3 to 11 except 4, read back and measured; halving
        // code stays out, the oscillator is taken to be fast
        for (k = 3; k <= 11; k++) begin
            if (k == 4) continue;
            wb(1, OPS_IDX_PRESC_RAT, k[7:0], rd);
            wb(1, OPS_IDX_PRESC_RST, 8'h02, rd);
            wb(1, OPS_IDX_PRESC_RST, 8'h00, rd);
            wb(0, OPS_IDX_PRESC_RAT, 8'h00, rd); chk(rd, k);
            gap(n); chk(n, k);
        end
        // Held prescaler gives no ticks, release divides again
        wb(1, OPS_IDX_PRESC_RST, 8'h02, rd);
        n = 0;
        repeat (30) @(posedge clk_sys_i) n += (tick_o === 1'b1);
        chk(n, 0);
        wb(1, OPS_IDX_PRESC_RST, 8'h00, rd);
        gap(n); chk(n, 11);
        // Channel B mask frees B before any sync, A stays held
        wb(1, OPS_IDX_PRESC_RAT, 8'h03, rd);
        wb(1, OPS_IDX_SYNC_MASK, 8'h02, rd);
        n = 0;
        repeat (12) @(posedge clk_sys_i) n += (chan_o[1] === 1'b1);
        chk(n > 0, 1);
        chk(chan_o[0], 1'b0);
        drv_i <= 1'b1;
        @(posedge clk_sys_i) chk(drv_o, 1'b1);
        drv_i <= 1'b0;
        @(posedge clk_sys_i) chk(drv_o, 1'b0);
        // Unarmed soft sync waits for calibration and lock
        wb(1, OPS_IDX_SYNC_STAT, 8'h01, rd);
        wsync(20, seen); chk(seen, 1'b0);
        wb(0, OPS_IDX_SYNC_STAT, 8'h00, rd); chk(rd, 32'h30);
        cal_i <= 1'b1;
        lck_i <= 1'b1;
        wsync(12, seen); chk(seen, 1'b1);
        // Lock mask arms without lock; direct source fires at once
        cal_i <= 1'b0;
        lck_i <= 1'b0;
        wb(1, OPS_IDX_SYNC_MASK, 8'h06, rd);
        wb(1, OPS_IDX_SYNC_STAT, 8'h01, rd);
        wsync(6, seen); chk(seen, 1'b1);
        // Reference source waits for the reference edge
        wb(1, OPS_IDX_SYNC_MASK, 8'h04, rd);
        wb(1, OPS_IDX_SYNC_SRC, 8'h04, rd);
        wb(1, OPS_IDX_SYNC_STAT, 8'h01, rd);
        wsync(12, seen); chk(seen, 1'b0);
        ref_i <= 1'b1;
        wsync(10, seen); chk(seen, 1'b1);
        ref_i <= 1'b0;
        // Every auto code against each lock pin
        for (k = 0; k < 8; k++) begin
            wb(1, OPS_IDX_SYNC_SRC, {6'h0, k[2:1]}, rd);
            frq_i <= ~k[0];
            phs_i <= k[0];
            wsync(10, seen);
            chk(seen, (k == 2) || (k == 5));
            frq_i <= 1'b0;
            phs_i <= 1'b0;
            repeat (8) @(posedge clk_sys_i);
        end
        finish_test();
    end
endmodule
